// File: inc/scr_pkg.sv
`default_nettype none
package scr_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned WORD_W = ADDR_W + DATA_W;
  localparam logic [4:0]  LAST_BIT = 5'h17;   // 24th rising edge of a word
  localparam logic [4:0]  ADDR_LAST = 5'h07;  // 8th rising edge, address complete

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
  localparam logic [7:0] ADDR_READBACK   = 8'h01;
  localparam int unsigned NUM_REGS = 9;
  localparam int unsigned IDX_READBACK = 0;
  localparam int unsigned IDX_SYNC     = 1;
  localparam int unsigned IDX_RAMP     = 2;
  localparam int unsigned IDX_POWER    = 3;
  localparam int unsigned IDX_NOISE    = 4;
  localparam int unsigned IDX_FRAME    = 5;
  localparam int unsigned IDX_SEED_LO  = 6;
  localparam int unsigned IDX_INVERT   = 7;
  localparam int unsigned IDX_UPPER    = 8;
  // Stored registers, in index order
  localparam logic [7:0] REG_ADDR [NUM_REGS] = '{8'h01, 8'h02, 8'h0a, 8'h0f, 8'h14,
                                                 8'h1c, 8'h23, 8'h24, 8'hf0};
  // Bits that hold state; the rest read as zero
  localparam logic [15:0] REG_MASK [NUM_REGS] = '{16'h0011, 16'h2000, 16'hffff, 16'h07ff,
                                                  16'h00ff, 16'h7fff, 16'hffff, 16'hfeff,
                                                  16'hffff};
  localparam logic [15:0] REG_RESET [NUM_REGS] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                                   16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                                   16'h0000};

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned BIT_SOFT_RESET   = 0;
  localparam int unsigned BIT_READBACK     = 0;
  localparam int unsigned BIT_UPPER_ACCESS = 4;
  localparam int unsigned BIT_PATTERN_SYNC = 13;
  localparam int unsigned BIT_PARTIAL      = 8;
  localparam int unsigned BIT_FULL         = 9;
  localparam int unsigned BIT_PIN_FUNCTION = 10;
  localparam int unsigned BIT_FRAME_ENABLE = 14;
  localparam int unsigned SEED_HIGH_LSB    = 9;

  // ----------------------------------------------------------------
  // Operating defaults after reset
  // ----------------------------------------------------------------
  localparam logic [4:0] DEF_RESOLUTION   = 5'h0e;  // 14-bit conversion
  localparam logic [4:0] DEF_SERIAL_RATIO = 5'h0e;  // 14x serialization
  localparam logic [3:0] DEF_BIT_CLOCK    = 4'h7;   // 7x bit clock
  localparam logic [3:0] DEF_FRAME_CLOCK  = 4'h1;   // 1x frame clock
  localparam logic [1:0] DEF_WIRES        = 2'h1;   // one wire per channel
  localparam logic [3:0] DEF_GAIN_DB      = 4'h0;   // 0 dB digital gain

  // Maps a serial address to a storage index; bit 4 flags a hit
  function automatic logic [4:0] scr_decode(input logic [7:0] addr);
    logic [4:0] res;
    res = 5'h00;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (addr == REG_ADDR[i])
        res = {1'b1, 4'(i)};
    end
    return res;
  endfunction

endpackage
`default_nettype wire

// File: design/scr_link.sv
`timescale 1ns/1ps
`default_nettype none
module scr_link
  import scr_pkg::*;
(
  input  wire logic                       link_clock_i,
  input  wire logic                       rst_i,
  input  wire logic                       chip_select_low_n_i,
  input  wire logic                       serial_write_input_i,
  input  wire logic [NUM_REGS*DATA_W-1:0] read_image_i,
  input  wire logic                       upper_enable_i,
  output logic                            word_toggle_o,
  output logic [ADDR_W-1:0]               word_addr_o,
  output logic [DATA_W-1:0]               word_data_o,
  output logic                            serial_read_output_o
);

  // ----------------------------------------------------------------
  // Bit counting and shifting
  // ----------------------------------------------------------------
  logic [4:0]        bit_cnt;
  logic [WORD_W-2:0] shift;
  logic [ADDR_W-1:0] rd_addr;

  // Chip select high clears the position, so a new select starts a word
  always_ff @(posedge link_clock_i or posedge chip_select_low_n_i)
  begin
    if (chip_select_low_n_i)
      bit_cnt <= 5'h00;
    else
      bit_cnt <= (bit_cnt == LAST_BIT) ? 5'h00 : 5'(bit_cnt + 5'h01);
  end

  // Data pin sampled on every rising serial clock edge
  always_ff @(posedge link_clock_i)
  begin
    shift <= {shift[WORD_W-3:0], serial_write_input_i};
  end

  // Address seen by the readback path, taken at the 8th edge
  always_ff @(posedge link_clock_i)
  begin
    if (!chip_select_low_n_i && bit_cnt == ADDR_LAST)
      rd_addr <= {shift[ADDR_W-2:0], serial_write_input_i};
  end

  // Word handed over at the 24th edge; a partial word never gets here.
  // The async reset only keeps the toggle aligned with the core after reset.
  always_ff @(posedge link_clock_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      word_toggle_o <= 1'b0;
      word_addr_o   <= 8'h00;
      word_data_o   <= 16'h0000;
    end
    else if (!chip_select_low_n_i && bit_cnt == LAST_BIT)
    begin
      word_toggle_o <= ~word_toggle_o;
      word_addr_o   <= shift[WORD_W-2:DATA_W-1];
      word_data_o   <= {shift[DATA_W-2:0], serial_write_input_i};
    end
  end

  // ----------------------------------------------------------------
  // Readback data path
  // ----------------------------------------------------------------
  // Register contents are quasi-static here: in readback mode only the
  // readback register accepts writes, and that one is never returned.
  wire logic [4:0]        rd_dec   = scr_decode(rd_addr);
  wire logic              rd_upper = (rd_dec[3:0] == 4'(IDX_UPPER));
  wire logic              rd_ok    = rd_dec[4] && (rd_dec[3:0] != 4'(IDX_READBACK))
                                     && (!rd_upper || upper_enable_i);
  wire logic [DATA_W-1:0] rd_word  = rd_ok ? read_image_i[rd_dec[3:0]*DATA_W +: DATA_W]
                                           : 16'h0000;
  wire logic [4:0]        rd_pos   = 5'(LAST_BIT - bit_cnt);
  wire logic              rd_phase = (bit_cnt > ADDR_LAST);

  // Launch on the falling edge so the bit is settled at the next rising edge
  always_ff @(negedge link_clock_i or posedge chip_select_low_n_i)
  begin
    if (chip_select_low_n_i)
      serial_read_output_o <= 1'b0;
    else
      serial_read_output_o <= rd_phase & rd_word[rd_pos[3:0]];
  end

endmodule
`default_nettype wire

// File: design/scr_regs.sv
// What this block does
// - Read pin floats until readback enabled
// - Readback mode blocks writes except address 1
// - Readback enable bit lives at address 1
// - Address 1 cannot be read back
// - Read cycle shifts sixteen bits out serially
// - Clearing readback restores writes, floats read pin
// - Reset default: 14-bit, 14x, 7x, 1x
// - Defaults: no readback, global sleep, 0 dB
// - Address 0 bit 0 self-clearing soft reset
// - Address 1 bit 4 gates upper register
// - Address 2 bit 13 enables pattern sync
// - Address 0A holds ramp start value
// - Eight channel power-down bits at 0F
// - Bits 8, 9 pick partial or full sleep
// - Bit 10 sets sleep pin function
// - Address 14 enables per-channel noise suppression
// - Address 1C bit 14 substitutes frame pattern
// - Seed is 0x23 plus 0x24 top seven
// - Address 24 low byte swaps input polarity
// - One write updates several fields together
// - 24-bit words, commit on 24th edge
// - Reset pin pulse restores all defaults
`timescale 1ns/1ps
`default_nettype none
module scr_regs
  import scr_pkg::*;
#(
  parameter int unsigned CHANNELS = 8
)
(
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          link_clock_i,
  input  wire logic          chip_select_low_n_i,
  input  wire logic          serial_write_input_i,
  input  wire logic          reset_pin_i,
  input  wire logic          power_down_pin_i,
  output logic               serial_read_output_o,
  output logic               serial_read_output_oe_o,
  output logic               readback_mode_o,
  output logic               upper_space_access_enable_o,
  output logic               pattern_sync_enable_o,
  output logic [15:0]        ramp_start_value_o,
  output logic [CHANNELS-1:0] channel_power_down_o,
  output logic               partial_sleep_o,
  output logic               full_sleep_o,
  output logic [CHANNELS-1:0] channel_noise_suppress_o,
  output logic               frame_pattern_enable_o,
  output logic [13:0]        frame_pattern_bits_o,
  output logic [22:0]        pseudo_random_seed_o,
  output logic [CHANNELS-1:0] input_polarity_swap_o,
  output logic [4:0]         resolution_bits_o,
  output logic [4:0]         serial_ratio_o,
  output logic [3:0]         bit_clock_ratio_o,
  output logic [3:0]         frame_clock_ratio_o,
  output logic [1:0]         wires_per_channel_o,
  output logic [3:0]         digital_gain_db_o,
  output logic               digital_filters_enable_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  // Channel bits share one byte of each register, so eight is the limit
  if (CHANNELS < 1 || CHANNELS > 8)
  begin : g_bad_channels
    $error("CHANNELS must lie between 1 and 8");
  end

  // ----------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------
  logic                       link_toggle;
  logic [ADDR_W-1:0]          link_addr;
  logic [DATA_W-1:0]          link_data;
  logic [NUM_REGS*DATA_W-1:0] read_image;
  logic [DATA_W-1:0]          regs [NUM_REGS];

  // Everything clocked by the serial clock lives in the link module
  scr_link u_link
  (
    .link_clock_i         (link_clock_i),
    .rst_i                (rst_i),
    .chip_select_low_n_i  (chip_select_low_n_i),
    .serial_write_input_i (serial_write_input_i),
    .read_image_i         (read_image),
    .upper_enable_i       (regs[IDX_READBACK][BIT_UPPER_ACCESS]),
    .word_toggle_o        (link_toggle),
    .word_addr_o          (link_addr),
    .word_data_o          (link_data),
    .serial_read_output_o (serial_read_output_o)
  );

  // ----------------------------------------------------------------
  // Crossings into the core clock
  // ----------------------------------------------------------------
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic rpin_s1;
  logic rpin_s2;
  logic pdpin_s1;
  logic pdpin_s2;

  // Word toggle: two stages, then a third for edge detection
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_s3 <= 1'b0;
    end
    else
    begin
      tog_s1 <= link_toggle;
      tog_s2 <= tog_s1;
      tog_s3 <= tog_s2;
    end
  end

  // Reset and sleep pins come from the board, so synchronise both
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      rpin_s1  <= 1'b0;
      rpin_s2  <= 1'b0;
      pdpin_s1 <= 1'b0;
      pdpin_s2 <= 1'b0;
    end
    else
    begin
      rpin_s1  <= reset_pin_i;
      rpin_s2  <= rpin_s1;
      pdpin_s1 <= power_down_pin_i;
      pdpin_s2 <= pdpin_s1;
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  // The link word is held until the next 24 serial edges, far longer than
  // the three core cycles the toggle needs, so it is read here directly.
  wire logic       commit      = tog_s2 ^ tog_s3;
  wire logic [4:0] wr_dec      = scr_decode(link_addr);
  wire logic       readback_on = regs[IDX_READBACK][BIT_READBACK];
  wire logic       upper_on    = regs[IDX_READBACK][BIT_UPPER_ACCESS];
  wire logic       wr_allowed  = commit
                                 && (!readback_on || link_addr == ADDR_READBACK);
  wire logic       wr_upper    = (wr_dec[3:0] == 4'(IDX_UPPER));
  wire logic       wr_store    = wr_allowed && wr_dec[4]
                                 && (!wr_upper || upper_on);
  wire logic       soft_reset  = wr_allowed && link_addr == ADDR_SOFT_RESET
                                 && link_data[BIT_SOFT_RESET];
  // Pin pulse, core reset and soft reset all restore the defaults
  wire logic       to_defaults = rst_i || rpin_s2 || soft_reset;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  // The soft reset bit has no storage, so it is self-clearing and reads 0.
  // Undefined bits are masked off rather than trusted to arrive as zero.
  for (genvar i = 0; i < NUM_REGS; i++)
  begin : g_regs
    always_ff @(posedge clock_i)
    begin
      if (to_defaults)
        regs[i] <= REG_RESET[i];
      else if (wr_store && wr_dec[3:0] == 4'(i))
        regs[i] <= link_data & REG_MASK[i];
    end
    assign read_image[i*DATA_W +: DATA_W] = regs[i];
  end

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire logic [15:0] pwr_reg    = regs[IDX_POWER];
  wire logic        pin_asleep = pdpin_s2;
  wire logic        pin_part   = pwr_reg[BIT_PIN_FUNCTION];
  wire logic        next_part  = pwr_reg[BIT_PARTIAL] || (pin_asleep && pin_part);
  wire logic        next_full  = pwr_reg[BIT_FULL] || (pin_asleep && !pin_part);
  wire logic [22:0] next_seed  = {regs[IDX_INVERT][15:SEED_HIGH_LSB],
                                  regs[IDX_SEED_LO]};

  // ----------------------------------------------------------------
  // Read pin enable
  // ----------------------------------------------------------------
  // Floats after any reset and whenever the mode bit is clear
  always_ff @(posedge clock_i)
  begin
    if (to_defaults)
    begin
      serial_read_output_oe_o <= 1'b0;
      readback_mode_o         <= 1'b0;
    end
    else
    begin
      serial_read_output_oe_o <= readback_on;
      readback_mode_o         <= readback_on;
    end
  end

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  // Registered copies so every port comes straight from a flop
  always_ff @(posedge clock_i)
  begin
    if (to_defaults)
    begin
      upper_space_access_enable_o <= 1'b0;
      pattern_sync_enable_o       <= 1'b0;
      ramp_start_value_o          <= 16'h0000;
      frame_pattern_enable_o      <= 1'b0;
      frame_pattern_bits_o        <= 14'h0000;
      pseudo_random_seed_o        <= 23'h000000;
    end
    else
    begin
      upper_space_access_enable_o <= upper_on;
      pattern_sync_enable_o       <= regs[IDX_SYNC][BIT_PATTERN_SYNC];
      ramp_start_value_o          <= regs[IDX_RAMP];
      frame_pattern_enable_o      <= regs[IDX_FRAME][BIT_FRAME_ENABLE];
      frame_pattern_bits_o        <= regs[IDX_FRAME][13:0];
      pseudo_random_seed_o        <= next_seed;
    end
  end

  // Per-channel controls, one bit per converter channel
  always_ff @(posedge clock_i)
  begin
    if (to_defaults)
    begin
      channel_power_down_o     <= '0;
      channel_noise_suppress_o <= '0;
      input_polarity_swap_o    <= '0;
    end
    else
    begin
      channel_power_down_o     <= pwr_reg[CHANNELS-1:0];
      channel_noise_suppress_o <= regs[IDX_NOISE][CHANNELS-1:0];
      input_polarity_swap_o    <= regs[IDX_INVERT][CHANNELS-1:0];
    end
  end

  // Sleep modes: register request or pin, routed by the pin function bit.
  // With defaults the pin acts as a global full power-down.
  always_ff @(posedge clock_i)
  begin
    if (to_defaults)
    begin
      partial_sleep_o <= 1'b0;
      full_sleep_o    <= 1'b0;
    end
    else
    begin
      partial_sleep_o <= next_part;
      full_sleep_o    <= next_full;
    end
  end

  // ----------------------------------------------------------------
  // Operating mode after reset
  // ----------------------------------------------------------------
  // The registers that change these lie outside this block, so they hold
  // their reset defaults; the ports keep the datapath told of the mode.
  always_ff @(posedge clock_i)
  begin
    if (to_defaults)
    begin
      resolution_bits_o        <= DEF_RESOLUTION;
      serial_ratio_o           <= DEF_SERIAL_RATIO;
      bit_clock_ratio_o        <= DEF_BIT_CLOCK;
      frame_clock_ratio_o      <= DEF_FRAME_CLOCK;
      wires_per_channel_o      <= DEF_WIRES;
      digital_gain_db_o        <= DEF_GAIN_DB;
      digital_filters_enable_o <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: tb/scr_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module scr_regs_asserts
#(
  parameter int unsigned CHANNELS = 8
)
(
  input wire logic                clock_i,
  input wire logic                rst_i,
  input wire logic                reset_pin_i,
  input wire logic                power_down_pin_i,
  input wire logic                serial_read_output_oe_o,
  input wire logic                readback_mode_o,
  input wire logic [15:0]         ramp_start_value_o,
  input wire logic [CHANNELS-1:0] channel_power_down_o,
  input wire logic [CHANNELS-1:0] channel_noise_suppress_o,
  input wire logic                partial_sleep_o,
  input wire logic                full_sleep_o,
  input wire logic [4:0]          resolution_bits_o,
  input wire logic [4:0]          serial_ratio_o,
  input wire logic [3:0]          bit_clock_ratio_o,
  input wire logic [3:0]          frame_clock_ratio_o,
  input wire logic [1:0]          wires_per_channel_o,
  input wire logic [3:0]          digital_gain_db_o,
  input wire logic                digital_filters_enable_o
);
  // ----------
  // Properties
  // ----------
  // All checks live in the core clock domain
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  property p_oe_rst; $fell(rst_i) |-> !serial_read_output_oe_o; endproperty
  property p_oe_on; $rose(readback_mode_o) |-> ##[0:3] serial_read_output_oe_o; endproperty
  property p_oe_off; $fell(readback_mode_o) |-> ##[0:3] !serial_read_output_oe_o; endproperty
  // Stores are frozen while readback holds; only address 1 may change
  property p_hold;
    readback_mode_o && $past(readback_mode_o) |->
      $stable(ramp_start_value_o) && $stable(channel_power_down_o);
  endproperty
  property p_mode;
    resolution_bits_o == 5'h0e && serial_ratio_o == 5'h0e && bit_clock_ratio_o == 4'h7
      && frame_clock_ratio_o == 4'h1 && wires_per_channel_o == 2'h1;
  endproperty
  property p_dflt;
    $fell(rst_i) |-> !readback_mode_o && digital_gain_db_o == 4'h0
      && !digital_filters_enable_o && channel_noise_suppress_o == '0;
  endproperty
  // Pin held long enough to pass its synchronizer must pick one sleep kind
  property p_pin;
    (power_down_pin_i && !reset_pin_i) [*6] |-> partial_sleep_o || full_sleep_o;
  endproperty
  property p_hwrst;
    reset_pin_i [*3] |-> ##[0:6] (ramp_start_value_o == 16'h0000 && !readback_mode_o
      && channel_power_down_o == '0);
  endproperty

  a_oe_rst: assert property (p_oe_rst) else $error("read pin driven after reset");
  a_oe_on: assert property (p_oe_on) else $error("read pin not driven");
  a_oe_off: assert property (p_oe_off) else $error("read pin not released");
  a_hold: assert property (p_hold) else $error("write taken in readback");
  a_mode: assert property (p_mode) else $error("output format not default");
  a_dflt: assert property (p_dflt) else $error("reset defaults wrong");
  a_pin: assert property (p_pin) else $error("sleep pin ignored");
  a_hwrst: assert property (p_hwrst) else $error("reset pin ignored");

  c_read: cover property (readback_mode_o && serial_read_output_oe_o);
  c_exit: cover property ($fell(readback_mode_o));
  c_sleep: cover property (partial_sleep_o && power_down_pin_i);
endmodule
bind scr_regs scr_regs_asserts #(.CHANNELS(CHANNELS)) u_chk
(
  .clock_i(clock_i), .rst_i(rst_i), .reset_pin_i(reset_pin_i),
  .power_down_pin_i(power_down_pin_i), .serial_read_output_oe_o(serial_read_output_oe_o),
  .readback_mode_o(readback_mode_o), .ramp_start_value_o(ramp_start_value_o),
  .channel_power_down_o(channel_power_down_o),
  .channel_noise_suppress_o(channel_noise_suppress_o),
  .partial_sleep_o(partial_sleep_o), .full_sleep_o(full_sleep_o),
  .resolution_bits_o(resolution_bits_o), .serial_ratio_o(serial_ratio_o),
  .bit_clock_ratio_o(bit_clock_ratio_o), .frame_clock_ratio_o(frame_clock_ratio_o),
  .wires_per_channel_o(wires_per_channel_o), .digital_gain_db_o(digital_gain_db_o),
  .digital_filters_enable_o(digital_filters_enable_o)
);
`default_nettype wire

// File: tb/scr_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module scr_ctl_model
(
  input  wire logic serial_read_output_i,
  output logic      link_clock_o,
  output logic      chip_select_low_n_o,
  output logic      serial_write_input_o
);
  // ----------
  // Controller
  // ----------
  // Serial clock idles low and stands still between frames
  initial
  begin
    link_clock_o = 1'b0;
    chip_select_low_n_o = 1'b1;
    serial_write_input_o = 1'b0;
  end

  // Sends n bits of {addr, data}; a short n makes a truncated word
  task automatic xfer(input logic [7:0] a, input logic [15:0] d, input int n,
                      output logic [15:0] q);
    logic [23:0] w;
    w = {a, d};
    q = 16'h0000;
    #7;
    chip_select_low_n_o = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      serial_write_input_o = w[23-i];
      #24;
      link_clock_o = 1'b1;
      if (i >= 8)
        q = {q[14:0], serial_read_output_i};
      #24;
      link_clock_o = 1'b0;
    end
    #24;
    chip_select_low_n_o = 1'b1;
    // Released data line must not keep showing the last bit
    serial_write_input_o = ~serial_write_input_o;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_serial_config_readback_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_serial_config_readback_regs;
  logic             clock_i, rst_i, reset_pin_i, power_down_pin_i;
  wire logic        link_clock_i, chip_select_low_n_i, serial_write_input_i, read_pin;
  wire logic        serial_read_output_o, serial_read_output_oe_o, readback_mode_o;
  wire logic        upper_space_access_enable_o, pattern_sync_enable_o, partial_sleep_o;
  wire logic        full_sleep_o, frame_pattern_enable_o, digital_filters_enable_o;
  wire logic [15:0] ramp_start_value_o;
  wire logic [7:0]  channel_power_down_o, channel_noise_suppress_o, input_polarity_swap_o;
  wire logic [13:0] frame_pattern_bits_o;
  wire logic [22:0] pseudo_random_seed_o;
  wire logic [4:0]  resolution_bits_o, serial_ratio_o;
  wire logic [3:0]  bit_clock_ratio_o, frame_clock_ratio_o, digital_gain_db_o;
  wire logic [1:0]  wires_per_channel_o;
  int               errors, n_tests;
  logic [15:0]      q;

  // Read pin floats unless the device enables it
  assign read_pin = serial_read_output_oe_o ? serial_read_output_o : 1'bz;

  scr_regs #(.CHANNELS(8)) DUT
  (
    .clock_i, .rst_i, .link_clock_i, .chip_select_low_n_i, .serial_write_input_i,
    .reset_pin_i, .power_down_pin_i, .serial_read_output_o, .serial_read_output_oe_o,
    .readback_mode_o, .upper_space_access_enable_o, .pattern_sync_enable_o,
    .ramp_start_value_o, .channel_power_down_o, .partial_sleep_o, .full_sleep_o,
    .channel_noise_suppress_o, .frame_pattern_enable_o, .frame_pattern_bits_o,
    .pseudo_random_seed_o, .input_polarity_swap_o, .resolution_bits_o, .serial_ratio_o,
    .bit_clock_ratio_o, .frame_clock_ratio_o, .wires_per_channel_o, .digital_gain_db_o,
    .digital_filters_enable_o
  );

  scr_ctl_model u_ctl
  (
    .serial_read_output_i(read_pin), .link_clock_o(link_clock_i),
    .chip_select_low_n_o(chip_select_low_n_i), .serial_write_input_o(serial_write_input_i)
  );

  // ----------
  // Helpers
  // ----------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Register update lands a few core clocks after the 24th edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    u_ctl.xfer(a, d, 24, q);
    repeat (8) @(posedge clock_i);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    // Reading address 1 also writes it, so the data keeps the mode bits set
    u_ctl.xfer(a, 16'h0011, 24, q);
    chk(32'(q), 32'(e));
  endtask

  task automatic test_done();
    $display("comparisons=%0d mismatches=%0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_defaults();
    chk(32'({readback_mode_o, serial_read_output_oe_o}), 32'h0);
    chk(32'({resolution_bits_o, serial_ratio_o, bit_clock_ratio_o, frame_clock_ratio_o,
             wires_per_channel_o}), 32'h739c5);
    chk(32'({digital_gain_db_o, digital_filters_enable_o, channel_noise_suppress_o}),
        32'h0);
    $display("defaults done");
  endtask

  task automatic t_fields();
    wr(8'h0a, 16'ha5c3);
    wr(8'h0f, 16'h01c3);
    wr(8'h14, 16'h005a);
    wr(8'h1c, 16'h7abc);
    wr(8'h23, 16'h1234);
    wr(8'h24, 16'hfe81);
    wr(8'h02, 16'h2000);
    chk(32'(ramp_start_value_o), 32'ha5c3);
    chk(32'({partial_sleep_o, full_sleep_o, channel_power_down_o}), 32'h2c3);
    chk(32'(channel_noise_suppress_o), 32'h5a);
    chk(32'({frame_pattern_enable_o, frame_pattern_bits_o}), 32'h7abc);
    chk(32'(pseudo_random_seed_o), 32'h7f1234);
    chk(32'(input_polarity_swap_o), 32'h81);
    chk(32'(pattern_sync_enable_o), 32'h1);
    $display("fields done");
  endtask

  task automatic t_readback();
    wr(8'h01, 16'h0010);
    chk(32'(upper_space_access_enable_o), 32'h1);
    wr(8'hf0, 16'h5a5a);
    wr(8'h01, 16'h0011);
    chk(32'({readback_mode_o, serial_read_output_oe_o}), 32'h3);
    rd(8'h0a, 16'ha5c3);
    rd(8'h0f, 16'h01c3);
    rd(8'hf0, 16'h5a5a);
    rd(8'h01, 16'h0000);
    wr(8'h0a, 16'hffff);
    chk(32'(ramp_start_value_o), 32'ha5c3);
    wr(8'h01, 16'h0001);
    rd(8'hf0, 16'h0000);
    wr(8'h01, 16'h0000);
    chk(32'({readback_mode_o, serial_read_output_oe_o}), 32'h0);
    wr(8'h0a, 16'h1111);
    chk(32'(ramp_start_value_o), 32'h1111);
    $display("readback done");
  endtask

  task automatic t_partial_soft();
    u_ctl.xfer(8'h0a, 16'h2222, 20, q);
    repeat (8) @(posedge clock_i);
    #1;
    chk(32'(ramp_start_value_o), 32'h1111);
    wr(8'h00, 16'h0001);
    chk(32'({ramp_start_value_o, channel_power_down_o}), 32'h0);
    wr(8'h0a, 16'h0042);
    chk(32'(ramp_start_value_o), 32'h42);
    $display("partial and soft reset done");
  endtask

  task automatic t_pin();
    @(posedge clock_i) power_down_pin_i <= 1'b1;
    repeat (8) @(posedge clock_i);
    #1;
    chk(32'({partial_sleep_o, full_sleep_o}), 32'h1);
    wr(8'h0f, 16'h0400);
    chk(32'({partial_sleep_o, full_sleep_o}), 32'h2);
    wr(8'h0a, 16'h0077);
    wr(8'h01, 16'h0001);
    @(posedge clock_i) reset_pin_i <= 1'b1;
    repeat (4) @(posedge clock_i);
    reset_pin_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    #1;
    chk(32'({ramp_start_value_o, readback_mode_o, partial_sleep_o, full_sleep_o}),
        32'h1);
    @(posedge clock_i) power_down_pin_i <= 1'b0;
    $display("pin done");
  endtask

  // ----------
  // Run
  // ----------
  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  initial
  begin
    errors = 0;
    n_tests = 0;
    rst_i = 1'b1;
    reset_pin_i = 1'b0;
    power_down_pin_i = 1'b0;
    repeat (5) @(posedge clock_i);
    rst_i <= 1'b0;
    @(posedge clock_i);
    #1;
    t_defaults();
    t_fields();
    t_readback();
    t_partial_soft();
    t_pin();
    test_done();
  end

  // Whole run needs about 37 us; a hang is cut off well beyond that
  initial
  begin
    #400000;
    errors++;
    test_done();
  end
endmodule
`default_nettype wire
